// ---- src/pio_top.v ----
// Summary of operation
// - Three bidirectional ports, per-pin switchable pull-ups except port two pins 3, 6 and 7.
// - Pull-ups are enabled after reset.
// - Pull-up off makes pin open-drain.
// - One pull-up register per port.
// - Port latch captures bus on write.
// - Latch-read strobe returns stored latch values.
// - Pin-read strobe returns sensed pin levels.
// - Reads split into latch and pin classes.
// - Enabled peripheral owns its pins while their latch bits are one.
// - Pulled-up output: zero low, one high.
// - Open-drain pin with zero drives low.
// - Carrier output is level XOR 38 kHz.
// - Global enable bit gates the modulation.
// - Eight pins selectable for modulation.
// - Pull-up register bit one disables pull-up.
// - Select bits map to eight fixed pins.
// - Port zero and one latches reset ones.
`timescale 1ns/100ps
module pio_top (
   input  wire        i_core_clk,          // Core clock
   input  wire        i_rst,               // Synchronous reset, active high
   input  wire [7:0]  i_sfr_addr,          // Register address
   input  wire [7:0]  i_sfr_wdata,         // Internal bus write data
   input  wire        i_sfr_wr,            // Write strobe
   input  wire        i_rd_latch,          // Latch-read strobe
   input  wire        i_rd_pin,            // Pin-read strobe
   input  wire        i_modulation_global_enable, // Carrier on/off
   input  wire [23:0] i_alt_en,            // Peripheral owns this pin
   input  wire [23:0] i_alt_out,           // Peripheral output level
   input  wire [7:0]  i_port0_pad,         // Sensed levels, port zero
   input  wire [7:0]  i_port1_pad,         // Sensed levels, port one
   input  wire [7:0]  i_port2_pad,         // Sensed levels, port two
   output reg  [7:0]  o_sfr_rdata,         // Read data to internal bus
   output reg         o_sfr_rvalid,        // Read data valid, one cycle
   output wire [7:0]  o_port0_out,         // Pad output value, port zero
   output wire [7:0]  o_port0_oe,          // Low-driver enable, port zero
   output wire [7:0]  o_port0_pullup_en,   // Weak pull-up enable, port zero
   output wire [7:0]  o_port1_out,         // Pad output value, port one
   output wire [7:0]  o_port1_oe,          // Low-driver enable, port one
   output wire [7:0]  o_port1_pullup_en,   // Weak pull-up enable, port one
   output wire [7:0]  o_port2_out,         // Pad output value, port two
   output wire [7:0]  o_port2_oe,          // Low-driver enable, port two
   output wire [7:0]  o_port2_pullup_en,   // Weak pull-up enable, port two
   output reg  [7:0]  o_port0_latch,       // Latch contents, port zero
   output reg  [7:0]  o_port1_latch,       // Latch contents, port one
   output reg  [7:0]  o_port2_latch        // Latch contents, port two
);
`include "pio_defines.vh"

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------

   reg  [7:0]  port_zero_pullup_disable;   // One bit per pin, 1 = off
   reg  [7:0]  port_one_pullup_disable;    // One bit per pin, 1 = off
   reg  [7:0]  port_two_pullup_disable;    // Only implemented bits held
   reg  [7:0]  modulation_pin_select;      // Carrier routing per pin

   // Pad outputs are constant zero; a flip-flop keeps them registered
   reg  [23:0] pad_out;                    // Always low

   // Flat views used by the per-pin logic
   wire [23:0] latch_all;                  // All port latches
   wire [23:0] pudis_all;                  // All pull-up disables
   wire [23:0] mod_sel_all;                // Carrier routing per pin
   wire [23:0] level_gp;                   // Level before the carrier
   wire [23:0] level_pin;                  // Final level per pin
   wire [23:0] drive_low;                  // Low-driver enables
   wire [23:0] pullup_en;                  // Pull-up enables
   wire        carrier;                    // Square wave
   wire        mod_on;                     // Carrier globally enabled

   // Read path helpers
   reg  [7:0]  next_rdata;                 // Read data before the flop
   wire        any_read;                   // Either read strobe active

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------

   // True when the given address decodes to the given register
   function hit;
      input [7:0] addr;
      input [7:0] reg_addr;
      begin
         hit = (addr == reg_addr);
      end
   endfunction

   // Spread the eight select bits onto the 24 flat pin positions
   function [23:0] spread_select;
      input [7:0] sel;
      reg   [23:0] m;
      begin
         m = 24'h000000;
         m[`PIO_BASE_P1 + 6] = sel[`PIO_MS_P16];
         m[`PIO_BASE_P1 + 5] = sel[`PIO_MS_P15];
         m[`PIO_BASE_P1 + 4] = sel[`PIO_MS_P14];
         m[`PIO_BASE_P1 + 1] = sel[`PIO_MS_P11];
         m[`PIO_BASE_P0 + 2] = sel[`PIO_MS_P02];
         m[`PIO_BASE_P0 + 7] = sel[`PIO_MS_P07];
         m[`PIO_BASE_P0 + 5] = sel[`PIO_MS_P05];
         m[`PIO_BASE_P0 + 3] = sel[`PIO_MS_P03];
         spread_select = m;
      end
   endfunction

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------

   // Every register takes the internal bus on the shared write strobe when its address matches; port two pull-up keeps only its implemented bits.
   // Writes are byte-wide; bit instructions arrive here already merged
   // by the CPU from a latch read, so a pin held low from outside never
   // leaks into the written value.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_port0_latch            <= `PIO_RST_LATCH;
         o_port1_latch            <= `PIO_RST_LATCH;
         o_port2_latch            <= `PIO_RST_LATCH;
         port_zero_pullup_disable <= `PIO_RST_PUDIS;
         port_one_pullup_disable  <= `PIO_RST_PUDIS;
         port_two_pullup_disable  <= `PIO_RST_PUDIS;
         modulation_pin_select    <= `PIO_RST_MODSEL;
      end else if (i_sfr_wr) begin
         // Port latches
         if (hit(i_sfr_addr, `PIO_ADDR_PORT0)) begin
            o_port0_latch <= i_sfr_wdata;
         end
         if (hit(i_sfr_addr, `PIO_ADDR_PORT1)) begin
            o_port1_latch <= i_sfr_wdata;
         end
         if (hit(i_sfr_addr, `PIO_ADDR_PORT2)) begin
            o_port2_latch <= i_sfr_wdata;
         end
         // Pull-up configuration, one register per port
         if (hit(i_sfr_addr, `PIO_ADDR_PUDIS0)) begin
            port_zero_pullup_disable <= i_sfr_wdata;
         end
         if (hit(i_sfr_addr, `PIO_ADDR_PUDIS1)) begin
            port_one_pullup_disable <= i_sfr_wdata;
         end
         if (hit(i_sfr_addr, `PIO_ADDR_PUDIS2)) begin
            // Reserved bits are not stored and read back as zero
            port_two_pullup_disable <= i_sfr_wdata & `PIO_PUDIS2_MASK;
         end
         // Carrier routing
         if (hit(i_sfr_addr, `PIO_ADDR_MODSEL)) begin
            modulation_pin_select <= i_sfr_wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------

   assign any_read = i_rd_latch | i_rd_pin;

   // Port registers answer with the latch or with the pad level,
   // depending on which strobe the CPU raised. Read-modify-write
   // instructions raise the latch strobe, so a one written to an
   // output that is shorted low is read back as one.
   // If both strobes come together the latch wins, the safe side
   // for a read-modify-write. Configuration registers answer the same
   // to either strobe.
   always @* begin
      next_rdata = `PIO_RST_RDATA;
      case (i_sfr_addr)
         `PIO_ADDR_PORT0: begin
            if (i_rd_latch) begin
               next_rdata = o_port0_latch;
            end else begin
               next_rdata = i_port0_pad;
            end
         end
         `PIO_ADDR_PORT1: begin
            if (i_rd_latch) begin
               next_rdata = o_port1_latch;
            end else begin
               next_rdata = i_port1_pad;
            end
         end
         `PIO_ADDR_PORT2: begin
            if (i_rd_latch) begin
               next_rdata = o_port2_latch;
            end else begin
               next_rdata = i_port2_pad;
            end
         end
         `PIO_ADDR_MODSEL: begin
            next_rdata = modulation_pin_select;
         end
         `PIO_ADDR_PUDIS0: begin
            next_rdata = port_zero_pullup_disable;
         end
         `PIO_ADDR_PUDIS1: begin
            next_rdata = port_one_pullup_disable;
         end
         `PIO_ADDR_PUDIS2: begin
            next_rdata = port_two_pullup_disable;
         end
         default: begin
            // Unmapped address reads as zero
            next_rdata = `PIO_RST_RDATA;
         end
      endcase
   end

   // Read data is registered: valid one cycle after the strobe.
   // Data holds until the next read so a slow consumer may sample it.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_sfr_rdata  <= `PIO_RST_RDATA;
         o_sfr_rvalid <= 1'b0;
      end else begin
         o_sfr_rvalid <= any_read;
         if (any_read) begin
            o_sfr_rdata <= next_rdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Carrier generator
   // ------------------------------------------------------------

   pio_carrier u_carrier (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .o_wave     (carrier)
   );

   // The global enable arrives from the configuration register that
   // lives outside this block; it is treated as synchronous.
   assign mod_on      = i_modulation_global_enable;
   assign mod_sel_all = spread_select(modulation_pin_select);

   // ------------------------------------------------------------
   // Per-pin level and driver
   // ------------------------------------------------------------

   assign latch_all = {o_port2_latch, o_port1_latch, o_port0_latch};
   assign pudis_all = {port_two_pullup_disable,
                       port_one_pullup_disable,
                       port_zero_pullup_disable};

   genvar g;
   generate
      for (g = 0; g < 24; g = g + 1) begin : g_pin
         // A pin owned by an enabled peripheral follows that peripheral.
         // The latch is still ANDed in, which is why software must keep
         // it at one: a zero latch would hold the pin low regardless.
         assign level_gp[g] = i_alt_en[g] ? (i_alt_out[g] & latch_all[g])
                                          : latch_all[g];
         // Modulated pins carry level XOR carrier; a written zero then
         // toggles at the carrier rate. Unselected pins pass through.
         assign level_pin[g] = (mod_on & mod_sel_all[g]) ? (level_gp[g] ^ carrier)
                                                          : level_gp[g];

         // Driver: a one releases the pin, so it reads as input (with
         // the pull-up holding it high, or floating when open-drain).
         pio_pin u_pin (
            .i_core_clk   (i_core_clk),
            .i_rst        (i_rst),
            .i_level      (level_pin[g]),
            .i_pu_disable (pudis_all[g]),
            .o_drive_low  (drive_low[g]),
            .o_pullup_en  (pullup_en[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Pad value
   // ------------------------------------------------------------

   // The pad data is always low; only the enable moves. Kept as a flop
   // so every pad output leaves a register.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         pad_out <= 24'h000000;
      end else begin
         pad_out <= 24'h000000;
      end
   end

   // ------------------------------------------------------------
   // Output mapping
   // ------------------------------------------------------------

   assign o_port0_out       = pad_out[`PIO_BASE_P0 +: 8];
   assign o_port1_out       = pad_out[`PIO_BASE_P1 +: 8];
   assign o_port2_out       = pad_out[`PIO_BASE_P2 +: 8];
   assign o_port0_oe        = drive_low[`PIO_BASE_P0 +: 8];
   assign o_port1_oe        = drive_low[`PIO_BASE_P1 +: 8];
   assign o_port2_oe        = drive_low[`PIO_BASE_P2 +: 8];
   assign o_port0_pullup_en = pullup_en[`PIO_BASE_P0 +: 8];
   assign o_port1_pullup_en = pullup_en[`PIO_BASE_P1 +: 8];
   assign o_port2_pullup_en = pullup_en[`PIO_BASE_P2 +: 8];

endmodule

// ---- pkg/pio_defines.vh ----
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH

// Special-function register addresses
`define PIO_ADDR_PORT0     8'h80
`define PIO_ADDR_PORT1     8'h90
`define PIO_ADDR_MODSEL    8'h9f
`define PIO_ADDR_PORT2     8'ha0
`define PIO_ADDR_PUDIS0    8'hb2
`define PIO_ADDR_PUDIS1    8'hb3
`define PIO_ADDR_PUDIS2    8'hb4

// Reset values
`define PIO_RST_LATCH      8'hff
`define PIO_RST_PUDIS      8'h00
`define PIO_RST_MODSEL     8'h00
`define PIO_RST_RDATA      8'h00

// Implemented bits of the port two pull-up register, the rest read zero
`define PIO_PUDIS2_MASK    8'h37

// Modulation pin-select bit positions
`define PIO_MS_P16         7
`define PIO_MS_P15         6
`define PIO_MS_P14         5
`define PIO_MS_P11         4
`define PIO_MS_P02         3
`define PIO_MS_P07         2
`define PIO_MS_P05         1
`define PIO_MS_P03         0

// Flat pin index of each port's bit zero
`define PIO_BASE_P0        0
`define PIO_BASE_P1        8
`define PIO_BASE_P2        16

// Carrier timing: clock and carrier rates in Hz
`define PIO_CLK_HZ         125000000
`define PIO_CARRIER_HZ     38000
// Half period in clock cycles, rounded to nearest
`define PIO_HALF_CYCLES    ((`PIO_CLK_HZ + `PIO_CARRIER_HZ) / (2 * `PIO_CARRIER_HZ))
`define PIO_CNT_W          11
`define PIO_CNT_ZERO       11'h000

`endif

// ---- src/pio_carrier.v ----
`timescale 1ns/100ps
// Free-running square wave at the carrier rate
module pio_carrier (
   input  wire i_core_clk,   // Core clock
   input  wire i_rst,        // Synchronous reset, active high
   output reg  o_wave        // Square wave, 50 percent duty
);
`include "pio_defines.vh"

   // Integer form first, then cut to the counter width on purpose
   localparam integer          HALF_INT  = `PIO_HALF_CYCLES - 1;
   localparam [`PIO_CNT_W-1:0] HALF_LAST = HALF_INT[`PIO_CNT_W-1:0];

   reg [`PIO_CNT_W-1:0] count;   // Cycles into the current half period

   // Divide the core clock; one toggle per half period
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         count  <= `PIO_CNT_ZERO;
         o_wave <= 1'b0;
      end else if (count == HALF_LAST) begin
         count  <= `PIO_CNT_ZERO;
         o_wave <= ~o_wave;
      end else begin
         count  <= count + 1'b1;
      end
   end

endmodule

// ---- src/pio_pin.v ----
`timescale 1ns/100ps
// One pin driver: low-side driver plus weak pull-up control
module pio_pin (
   input  wire i_core_clk,    // Core clock
   input  wire i_rst,         // Synchronous reset, active high
   input  wire i_level,       // Level the pin should show
   input  wire i_pu_disable,  // Pull-up disable bit for this pin
   output reg  o_drive_low,   // Output enable of the low driver
   output reg  o_pullup_en    // Weak pull-up enable to the pad
);

   // The pad only ever drives low; a one is left to the pull-up or
   // to an external resistor, so two pins tied together never fight.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_drive_low <= 1'b0;     // Latch resets high: pin released
         o_pullup_en <= 1'b1;
      end else begin
         o_drive_low <= ~i_level;
         o_pullup_en <= ~i_pu_disable;
      end
   end

endmodule

// ---- testbench/pio_props.sv ----
`timescale 1ns/100ps
// Watches register bus and pad controls of the port block
module pio_props (
   input wire        i_core_clk,
   input wire        i_rst,
   input wire [7:0]  i_sfr_addr,
   input wire [7:0]  i_sfr_wdata,
   input wire        i_sfr_wr,
   input wire        i_rd_latch,
   input wire        i_rd_pin,
   input wire        i_modulation_global_enable,
   input wire [23:0] i_alt_en,
   input wire [23:0] i_alt_out,
   input wire [7:0]  i_port1_pad,
   input wire [7:0]  o_sfr_rdata,
   input wire        o_sfr_rvalid,
   input wire [7:0]  o_port0_oe,
   input wire [7:0]  o_port1_oe,
   input wire [7:0]  o_port0_pullup_en,
   input wire [7:0]  o_port2_pullup_en,
   input wire [7:0]  o_port0_latch,
   input wire [7:0]  o_port1_latch
);
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   AST_RVALID:
      assert property ((i_rd_latch || i_rd_pin) |=> o_sfr_rvalid) else $error("read lost");
   AST_RVALID_ONE:
      assert property (!(i_rd_latch || i_rd_pin) |=> !o_sfr_rvalid) else $error("stray valid");
   AST_LATCH_WRITE:
      assert property ((i_sfr_wr && i_sfr_addr == 8'h80) |=> o_port0_latch == $past(i_sfr_wdata))
      else $error("latch write lost");
   AST_LATCH_READ:
      assert property ((i_rd_latch && i_sfr_addr == 8'h90) |=> o_sfr_rdata == $past(o_port1_latch))
      else $error("latch read wrong");
   AST_PIN_READ:
      assert property ((i_rd_pin && !i_rd_latch && i_sfr_addr == 8'h90)
         |=> o_sfr_rdata == $past(i_port1_pad)) else $error("pin read wrong");
   AST_UNMAPPED:
      assert property ((i_rd_latch && i_sfr_addr == 8'h81) |=> o_sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_PUDIS_APPLY:
      assert property ((i_sfr_wr && i_sfr_addr == 8'hb2) ##1 !i_rst
         |=> o_port0_pullup_en == ~$past(i_sfr_wdata, 2)) else $error("pull-up not applied");
   AST_RESET_STATE:
      assert property ($past(i_rst) |-> (o_port0_latch == 8'hff && o_port1_latch == 8'hff
         && o_port0_pullup_en == 8'hff)) else $error("bad state after reset");
   AST_PORT0_OE:
      assert property ((!$past(i_rst) && !$past(i_modulation_global_enable))
         |-> o_port0_oe == ~($past(o_port0_latch) & (~$past(i_alt_en[7:0])
         | $past(i_alt_out[7:0])))) else $error("port zero driver wrong");
   AST_PORT1_OE:
      assert property ((!$past(i_rst) && !$past(i_modulation_global_enable))
         |-> o_port1_oe == ~($past(o_port1_latch) & (~$past(i_alt_en[15:8])
         | $past(i_alt_out[15:8])))) else $error("port one driver wrong");
   AST_PULLUP_HOLD:
      assert property ((!$past(i_sfr_wr) && !$past(i_sfr_wr, 2) && !$past(i_rst))
         |-> $stable(o_port2_pullup_en)) else $error("pull-up moved alone");

   // Main scenarios reached
   cover property (i_sfr_wr && i_sfr_addr == 8'h9f);
   cover property (i_rd_pin ##1 o_sfr_rvalid);
   cover property (i_modulation_global_enable && $changed(o_port0_oe));
endmodule

bind pio_top pio_props i_pio_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr),
   .i_rd_latch(i_rd_latch), .i_rd_pin(i_rd_pin),
   .i_modulation_global_enable(i_modulation_global_enable), .i_alt_en(i_alt_en),
   .i_alt_out(i_alt_out), .i_port1_pad(i_port1_pad), .o_sfr_rdata(o_sfr_rdata),
   .o_sfr_rvalid(o_sfr_rvalid), .o_port0_oe(o_port0_oe), .o_port1_oe(o_port1_oe),
   .o_port0_pullup_en(o_port0_pullup_en), .o_port2_pullup_en(o_port2_pullup_en),
   .o_port0_latch(o_port0_latch), .o_port1_latch(o_port1_latch));

// ---- testbench/pio_pad_model.sv ----
`timescale 1ns/100ps
// Board side of the pads: external drivers, resistors, floating lines
module pio_pad_model (
   input  wire        i_core_clk,   // Paces the floating pattern
   input  wire [23:0] i_drive_low,  // Low-driver enables from the port
   input  wire [23:0] i_pullup_en,  // Weak pull-up enables from the port
   input  wire [23:0] i_ext_low,    // External device holding a pin low
   input  wire [23:0] i_ext_pullup, // Board resistor to the high rail
   output wire [23:0] o_pad         // Level each input buffer senses
);
   reg [23:0] float_pat = 24'h555555; // Stand-in for an undriven line

   // A floating pin has no stable level, so it wanders every cycle
   always @(posedge i_core_clk) begin
      float_pat <= ~float_pat;
   end

   // Any low driver wins, then a pull-up, else the line floats
   assign o_pad = ~(i_drive_low | i_ext_low) & (i_pullup_en | i_ext_pullup | float_pat);
endmodule

// ---- testbench/pio_top_tb.sv ----
`timescale 1ns/100ps
// Register-level tests of the port block against a pad model
module pio_top_tb;
   localparam [55:0] reg_map = 56'h80_90_a0_9f_b2_b3_b4; // Mapped addresses
   localparam [39:0] sel_map = {5'd14, 5'd13, 5'd12, 5'd9, 5'd2, 5'd7, 5'd5, 5'd3};
   reg         i_core_clk;   // Core clock
   reg         i_rst;        // Synchronous reset
   reg  [7:0]  addr;         // Register address
   reg  [7:0]  wdata;        // Write data
   reg         wr;           // Write strobe
   reg         rd_latch;     // Latch-read strobe
   reg         rd_pin;       // Pin-read strobe
   reg         mod_en;       // Carrier global enable
   reg  [23:0] alt_en;       // Peripheral ownership
   reg  [23:0] alt_out;      // Peripheral levels
   reg  [23:0] ext_low;      // External low drivers
   reg  [23:0] ext_pu;       // Board pull-ups
   wire [23:0] pad;          // Sensed pad levels
   wire [23:0] oe;           // Low-driver enables
   wire [23:0] pu;           // Pull-up enables
   wire [23:0] pout;         // Pad data outputs
   wire [23:0] lat;          // Latch contents
   wire [7:0]  rdata;        // Read data
   wire        rvalid;       // Read valid
   integer     bad_count;
   integer     num_checks;
   integer     i;
   integer     n;
   reg  [7:0]  v;            // Expected read value

   pio_top i_pio_top (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_sfr_addr(addr),
      .i_sfr_wdata(wdata), .i_sfr_wr(wr), .i_rd_latch(rd_latch), .i_rd_pin(rd_pin),
      .i_modulation_global_enable(mod_en), .i_alt_en(alt_en), .i_alt_out(alt_out),
      .i_port0_pad(pad[7:0]), .i_port1_pad(pad[15:8]), .i_port2_pad(pad[23:16]),
      .o_sfr_rdata(rdata), .o_sfr_rvalid(rvalid), .o_port0_out(pout[7:0]),
      .o_port0_oe(oe[7:0]), .o_port0_pullup_en(pu[7:0]), .o_port1_out(pout[15:8]),
      .o_port1_oe(oe[15:8]), .o_port1_pullup_en(pu[15:8]), .o_port2_out(pout[23:16]),
      .o_port2_oe(oe[23:16]), .o_port2_pullup_en(pu[23:16]), .o_port0_latch(lat[7:0]),
      .o_port1_latch(lat[15:8]), .o_port2_latch(lat[23:16]));

   pio_pad_model i_pio_pad_model (.i_core_clk(i_core_clk), .i_drive_low(oe),
      .i_pullup_en(pu), .i_ext_low(ext_low), .i_ext_pullup(ext_pu), .o_pad(pad));

   // Compare and count
   task chk(input [23:0] seen, input [23:0] want);
      begin
         num_checks = num_checks + 1;
         if (seen !== want) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
         end
      end
   endtask

   // One-cycle write strobe, driven off the sampling edge
   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         @(negedge i_core_clk);
         addr = a;
         wdata = d;
         wr = 1'b1;
         @(negedge i_core_clk);
         wr = 1'b0;
      end
   endtask

   // Read through latch or pin path; valid shows one cycle later
   task rd_chk(input pin, input [7:0] a, input [7:0] want);
      begin
         @(negedge i_core_clk);
         addr = a;
         rd_pin = pin;
         rd_latch = ~pin;
         @(negedge i_core_clk);
         rd_pin = 1'b0;
         rd_latch = 1'b0;
         chk({23'h0, rvalid}, 24'h1);
         chk({16'h0, rdata}, {16'h0, want});
      end
   endtask

   // Cycles between two driver changes on pin p, capped so a dead pin ends
   task half(input integer p, output integer cnt);
      reg last;
      begin
         cnt = 0;
         last = oe[p];
         while (oe[p] === last && cnt < 1700) begin
            @(negedge i_core_clk);
            cnt = cnt + 1;
         end
         cnt = 0;
         last = oe[p];
         while (oe[p] === last && cnt < 1700) begin
            @(negedge i_core_clk);
            cnt = cnt + 1;
         end
      end
   endtask

   // Verdict, the single place the run ends
   task stop_test;
      begin
         if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask

   // Clock, 8 ns period
   initial begin
      i_core_clk = 1'b0;
      forever #4 i_core_clk = ~i_core_clk;
   end

   // Watchdog sized well above the carrier sweeps
   initial begin
      repeat (60000) @(posedge i_core_clk);
      bad_count = bad_count + 1;
      stop_test;
   end

   // Test sequence
   initial begin
      {addr, wdata, wr, rd_latch, rd_pin, mod_en} = 21'h0;
      {alt_en, alt_out, ext_low, ext_pu} = 96'h0;
      bad_count = 0;
      num_checks = 0;
      i_rst = 1'b1;
      repeat (8) @(negedge i_core_clk);
      i_rst = 1'b0;
      // Reset values of every register and pad control
      for (i = 0; i < 7; i = i + 1) begin
         rd_chk(1'b0, reg_map[55 - 8 * i -: 8], (i < 3) ? 8'hff : 8'h00);
      end
      chk(pu, 24'hffffff);
      chk(oe, 24'h000000);
      chk(lat, 24'hffffff);
      chk(pout, 24'h000000);
      // Write and read back; port two pull-up keeps only its real bits
      for (i = 0; i < 7; i = i + 1) begin
         wr_reg(reg_map[55 - 8 * i -: 8], 8'h5a);
         v = (i == 6) ? 8'h12 : 8'h5a;
         rd_chk(1'b0, reg_map[55 - 8 * i -: 8], v);
      end
      wr_reg(8'h81, 8'hff);
      rd_chk(1'b0, 8'h81, 8'h00);
      rd_chk(1'b0, 8'h80, 8'h5a);
      for (i = 3; i < 7; i = i + 1) begin
         wr_reg(reg_map[55 - 8 * i -: 8], 8'h00);
      end
      // Pulled-up pins follow the latch; pin and latch reads differ
      wr_reg(8'h80, 8'h5a);
      repeat (2) @(negedge i_core_clk);
      chk(oe[7:0], 8'ha5);
      ext_low = 24'h000002;
      rd_chk(1'b1, 8'h80, 8'h58);
      rd_chk(1'b0, 8'h80, 8'h5a);
      ext_low = 24'h000000;
      // Open drain: pull-ups off, board resistor supplies the high
      wr_reg(8'hb2, 8'hff);
      wr_reg(8'hb3, 8'h80);
      wr_reg(8'hb4, 8'hff);
      repeat (2) @(negedge i_core_clk);
      chk(pu, 24'hc87f00);
      ext_pu = 24'h0000ff;
      rd_chk(1'b1, 8'h80, 8'h5a);
      wr_reg(8'h80, 8'h00);
      repeat (2) @(negedge i_core_clk);
      chk(oe[7:0], 8'hff);
      ext_pu = 24'h000000;
      // Peripheral owns P1.0 while its latch bit stays one
      wr_reg(8'h90, 8'hff);
      chk(lat[15:8], 8'hff);
      alt_en = 24'h000100;
      repeat (2) @(negedge i_core_clk);
      chk(oe[15:8], 8'h01);
      alt_out = 24'h000100;
      repeat (2) @(negedge i_core_clk);
      chk(oe[15:8], 8'h00);
      alt_en = 24'h000000;
      // Carrier on each selectable pin with its latch at zero
      wr_reg(8'h90, 8'h00);
      mod_en = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
         wr_reg(8'h9f, 8'h01 << i);
         half(sel_map[5 * i +: 5], n);
         chk(n[23:0], 24'h00066d);
      end
      // Global enable off freezes the last selected pin
      mod_en = 1'b0;
      half(14, n);
      chk(n[23:0], 24'h0006a4);
      stop_test;
   end
endmodule
